// >>> design/async_serial_receiver.sv
// asynchronous serial receiver with two-entry buffer and wishbone registers
//
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module async_serial_receiver
  import async_rx_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [31:0] wb_dat_in,
  input  wire logic [3:0]  wb_sel_in,
  output var  logic [31:0] wb_dat_out,
  output var  logic        wb_ack_out,
  input  wire logic        baud_tick_in,
  input  wire logic        receive_pin_in,
  output var  logic        receive_flag_out,
  output var  logic        rx_irq_out
);

  // ---------------------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------------------
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic pin_prev_reg;

  // only the second flop feeds logic; the first may still be settling
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
    end else begin
      pin_meta_reg <= receive_pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // registers and bus strobes
  // ---------------------------------------------------------------------------
  logic [7:0] rx_ctrl_reg;
  logic [7:0] tx_ctrl_reg;
  logic [7:0] baud_ctrl_reg;
  logic [7:0] div_low_reg;
  logic [7:0] div_high_reg;
  logic [2:0] int_ctrl_reg;
  logic       overrun_reg;

  // one select per register, shared by the write and read decodes except sel_rx_data, which only the read side uses
  logic sel_rx_ctrl;
  logic sel_rx_data;
  logic sel_tx_ctrl;
  logic sel_baud_ctrl;
  logic sel_div_low;
  logic sel_div_high;
  logic sel_int_ctrl;

  assign sel_rx_ctrl   = (wb_adr_in == ADDR_RX_STATUS_CONTROL);
  assign sel_rx_data   = (wb_adr_in == ADDR_RX_DATA);
  assign sel_tx_ctrl   = (wb_adr_in == ADDR_TX_STATUS_CONTROL);
  assign sel_baud_ctrl = (wb_adr_in == ADDR_BAUD_CONTROL);
  assign sel_div_low   = (wb_adr_in == ADDR_BAUD_DIV_LOW);
  assign sel_div_high  = (wb_adr_in == ADDR_BAUD_DIV_HIGH);
  assign sel_int_ctrl  = (wb_adr_in == ADDR_INT_CONTROL);

  logic bus_req;
  logic wr_stb;
  logic rd_stb;
  logic data_read;
  logic port_en;
  logic cont_rx;
  logic rx_active;

  assign bus_req   = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr_stb    = bus_req && wb_we_in && wb_sel_in[0];
  assign rd_stb    = bus_req && !wb_we_in;
  assign data_read = rd_stb && sel_rx_data;
  assign port_en   = rx_ctrl_reg[BIT_PORT_EN];
  assign cont_rx   = rx_ctrl_reg[BIT_CONT_RX];
  assign rx_active = cont_rx && !tx_ctrl_reg[BIT_SYNC] && port_en;

  // only writable bits are stored; flags live in their own flops
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_ctrl_reg   <= RESET_RX_CTRL;
      tx_ctrl_reg   <= RESET_TX_CTRL;
      baud_ctrl_reg <= RESET_BAUD_CTRL;
      div_low_reg   <= RESET_DIV;
      div_high_reg  <= RESET_DIV;
      int_ctrl_reg  <= RESET_INT_CTRL;
    end else if (wr_stb) begin
      if (sel_rx_ctrl) begin
        rx_ctrl_reg <= {wb_dat_in[7:3], 3'h0};
      end else if (sel_tx_ctrl) begin
        tx_ctrl_reg <= wb_dat_in[7:0];
      end else if (sel_baud_ctrl) begin
        baud_ctrl_reg <= {wb_dat_in[7], 1'b0, wb_dat_in[5:0]};
      end else if (sel_div_low) begin
        div_low_reg <= wb_dat_in[7:0];
      end else if (sel_div_high) begin
        div_high_reg <= wb_dat_in[7:0];
      end else if (sel_int_ctrl) begin
        int_ctrl_reg <= wb_dat_in[2:0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // receive state machine
  // ---------------------------------------------------------------------------
  rx_state_type state_reg;
  logic [3:0]   tick_cnt_reg;
  logic [3:0]   bit_cnt_reg;
  logic [8:0]   shift_reg;
  logic [2:0]   votes_reg;
  logic         char_done_reg;
  logic         char_framing_error_bit_reg;
  logic [3:0]   nbits;
  logic         vote;

  assign nbits = rx_ctrl_reg[BIT_NINE] ? DATA_BITS_9 : DATA_BITS_8;
  assign vote  = (votes_reg[0] & votes_reg[1]) | (votes_reg[0] & votes_reg[2]) |
                 (votes_reg[1] & votes_reg[2]);

  // three samples around each bit centre
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      votes_reg <= 3'h7;
    end else if (baud_tick_in) begin
      if (tick_cnt_reg == VOTE_S1 || tick_cnt_reg == VOTE_S2 || tick_cnt_reg == VOTE_S3) begin
        votes_reg <= {votes_reg[1:0], pin_sync_reg};
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg     <= RX_IDLE;
      tick_cnt_reg  <= 4'h0;
      bit_cnt_reg   <= 4'h0;
      shift_reg     <= 9'h000;
      pin_prev_reg  <= 1'b1;
      char_done_reg <= 1'b0;
      char_framing_error_bit_reg <= 1'b0;
    end else begin
      char_done_reg <= 1'b0;
      if (!rx_active || overrun_reg) begin
        state_reg    <= RX_IDLE;
        tick_cnt_reg <= 4'h0;
        pin_prev_reg <= 1'b1;
      end else if (baud_tick_in) begin
        pin_prev_reg <= pin_sync_reg;
        tick_cnt_reg <= tick_cnt_reg + 4'h1;
        case (state_reg)
          RX_IDLE: begin
            tick_cnt_reg <= 4'h0;
            if (pin_prev_reg && !pin_sync_reg) begin
              state_reg <= RX_START;
            end
          end
          RX_START: begin
            // count on through the start bit so each later window opens at a
            // bit edge and its three votes fall on the bit centre
            if (tick_cnt_reg == TICKS_HALF_BIT && pin_sync_reg) begin
              state_reg <= RX_IDLE;
            end else if (tick_cnt_reg == TICKS_FULL_BIT) begin
              state_reg   <= RX_DATA;
              bit_cnt_reg <= 4'h0;
            end
          end
          RX_DATA: begin
            if (tick_cnt_reg == TICKS_FULL_BIT) begin
              // lsb arrives first and ends at bit 0 after shifting
              if (rx_ctrl_reg[BIT_NINE]) begin
                shift_reg <= {vote, shift_reg[8:1]};
              end else begin
                shift_reg <= {1'b0, vote, shift_reg[7:1]};
              end
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (bit_cnt_reg + 4'h1 == nbits) begin
                state_reg <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            // decide as soon as the third vote is in, so a start edge right
            // after the stop bit still finds the machine idle
            if (tick_cnt_reg > VOTE_S3) begin
              char_framing_error_bit_reg <= !vote;
              char_done_reg <= 1'b1;
              state_reg     <= RX_IDLE;
            end
          end
          default: state_reg <= RX_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // two-entry buffer, each entry with its own framing status
  // ---------------------------------------------------------------------------
  logic [8:0] fifo_data_reg [0:1];
  logic       fifo_framing_error_bit_reg [0:1];
  logic [1:0] count_reg;
  logic       accept;
  logic       push;
  logic       pop;
  logic       third;
  logic       upper_slot;

  // address mode with nine-bit set drops characters whose ninth bit is clear
  assign accept = char_done_reg &&
                  !(rx_ctrl_reg[BIT_ADDR_DET] && rx_ctrl_reg[BIT_NINE] && !shift_reg[8]);
  assign pop    = data_read && (count_reg != 2'h0);
  assign third  = accept && (count_reg == 2'h2) && !pop;
  assign push   = accept && !third;

  // a push lands behind whatever survives this cycle's pop
  assign upper_slot = (count_reg - (pop ? 2'h1 : 2'h0)) != 2'h0;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_reg        <= 2'h0;
      fifo_data_reg[0] <= 9'h000;
      fifo_data_reg[1] <= 9'h000;
      fifo_framing_error_bit_reg[0] <= 1'b0;
      fifo_framing_error_bit_reg[1] <= 1'b0;
    end else if (!port_en) begin
      count_reg        <= 2'h0;
      fifo_framing_error_bit_reg[0] <= 1'b0;
      fifo_framing_error_bit_reg[1] <= 1'b0;
    end else begin
      // entry 0 is always the oldest
      if (pop) begin
        fifo_data_reg[0] <= fifo_data_reg[1];
        fifo_framing_error_bit_reg[0] <= fifo_framing_error_bit_reg[1];
      end
      if (push) begin
        if (!upper_slot) begin
          fifo_data_reg[0] <= shift_reg;
          fifo_framing_error_bit_reg[0] <= char_framing_error_bit_reg;
        end else begin
          fifo_data_reg[1] <= shift_reg;
          fifo_framing_error_bit_reg[1] <= char_framing_error_bit_reg;
        end
      end
      count_reg <= count_reg + (push ? 2'h1 : 2'h0) - (pop ? 2'h1 : 2'h0);
    end
  end

  // ---------------------------------------------------------------------------
  // overrun flag: the enable-driven clear wins over the set
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      overrun_reg <= 1'b0;
    end else if (third && rx_active) begin
      overrun_reg <= 1'b1;
    end else if (!cont_rx || !port_en) begin
      overrun_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // flag and interrupt outputs
  // ---------------------------------------------------------------------------
  logic flag_next;
  logic irq_next;

  // flag depends on buffer and port enable only; framing status feeds no request
  assign flag_next = (count_reg != 2'h0) && port_en;
  assign irq_next  = flag_next && int_ctrl_reg[BIT_RX_IE] &&
                     int_ctrl_reg[BIT_PERIPH_IE] && int_ctrl_reg[BIT_GLOBAL_IE];

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      receive_flag_out <= 1'b0;
    end else begin
      receive_flag_out <= flag_next;
    end
  end

  // the flag is set whatever the interrupt enables say; only the request is gated by them
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_irq_out <= 1'b0;
    end else begin
      rx_irq_out <= irq_next;
    end
  end

  // ---------------------------------------------------------------------------
  // read mux and acknowledge, one wait-free cycle
  // ---------------------------------------------------------------------------
  logic [7:0] status_view;
  logic [7:0] baud_view;
  logic [7:0] rd_data_next;

  // read-only bits come from live state at their own positions
  always_comb begin
    status_view                = rx_ctrl_reg;
    status_view[BIT_FRAME_ERR] = fifo_framing_error_bit_reg[0];
    status_view[BIT_OVERRUN]   = overrun_reg;
    status_view[BIT_NINTH]     = fifo_data_reg[0][8];
    baud_view                  = baud_ctrl_reg;
    baud_view[BIT_RX_IDLE]     = (state_reg == RX_IDLE);
  end

  // unmapped addresses read as zero
  always_comb begin
    rd_data_next = 8'h00;
    if (sel_rx_ctrl) begin
      rd_data_next = status_view;
    end else if (sel_rx_data) begin
      rd_data_next = fifo_data_reg[0][7:0];
    end else if (sel_tx_ctrl) begin
      rd_data_next = tx_ctrl_reg;
    end else if (sel_baud_ctrl) begin
      rd_data_next = baud_view;
    end else if (sel_div_low) begin
      rd_data_next = div_low_reg;
    end else if (sel_div_high) begin
      rd_data_next = div_high_reg;
    end else if (sel_int_ctrl) begin
      rd_data_next = {5'h00, int_ctrl_reg};
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= bus_req;
      // data stands only in the ack cycle
      wb_dat_out <= rd_stb ? {24'h000000, rd_data_next} : 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

// >>> design/async_rx_pkg.sv
// constants and register map of the asynchronous serial receiver
// What this block does
// - receive only when enabled, async, port on
// - sample line at sixteen times bit rate
// - confirm start bit low at half bit
// - high at start centre: abandon silently
// - majority vote at each bit centre, shift
// - stop sampled low marks framing error
// - finished character moves into two-entry buffer
// - data read returns oldest, removes it
// - receive flag mirrors unread data, read-only
// - interrupt needs all three enables set
// - each entry keeps its framing status
// - framing bit read-only, reception continues
// - port disable clears framing; receive disable not
// - framing error alone raises no interrupt
// - framing bit stays set if all bad
// - third character with full buffer sets overrun
// - overrun blocks reception, buffer stays readable
// - overrun cleared by receive or port disable
// - lsb first, idle mark, start space
// - nine-bit option, ninth bit readable
// - address detect in nine-bit mode keeps only ninth-bit-set characters
package async_rx_pkg;

  // ---------------------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_RX_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_RX_DATA           = 8'h04;
  localparam logic [7:0] ADDR_TX_STATUS_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_BAUD_CONTROL      = 8'h0C;
  localparam logic [7:0] ADDR_BAUD_DIV_LOW      = 8'h10;
  localparam logic [7:0] ADDR_BAUD_DIV_HIGH     = 8'h14;
  localparam logic [7:0] ADDR_INT_CONTROL       = 8'h18;

  // ---------------------------------------------------------------------------
  // receive status/control fields
  // ---------------------------------------------------------------------------
  localparam int BIT_PORT_EN   = 7;
  localparam int BIT_NINE      = 6;
  localparam int BIT_SREN      = 5;
  localparam int BIT_CONT_RX   = 4;
  localparam int BIT_ADDR_DET  = 3;
  localparam int BIT_FRAME_ERR = 2;
  localparam int BIT_OVERRUN   = 1;
  localparam int BIT_NINTH     = 0;
  // transmit status/control: synchronous select
  localparam int BIT_SYNC      = 4;
  // baud control: receiver idle
  localparam int BIT_RX_IDLE   = 6;
  // interrupt control (own register)
  localparam int BIT_GLOBAL_IE = 2;
  localparam int BIT_PERIPH_IE = 1;
  localparam int BIT_RX_IE     = 0;

  localparam logic [7:0] RESET_RX_CTRL   = 8'h00;
  localparam logic [7:0] RESET_TX_CTRL   = 8'h02;
  localparam logic [7:0] RESET_BAUD_CTRL = 8'h00;
  localparam logic [7:0] RESET_DIV       = 8'h00;
  localparam logic [2:0] RESET_INT_CTRL  = 3'h0;

  // ---------------------------------------------------------------------------
  // timing in sixteenth-bit ticks
  // ---------------------------------------------------------------------------
  localparam logic [3:0] TICKS_HALF_BIT = 4'h7;
  localparam logic [3:0] TICKS_FULL_BIT = 4'hF;
  localparam logic [3:0] VOTE_S1        = 4'h7;
  localparam logic [3:0] VOTE_S2        = 4'h8;
  localparam logic [3:0] VOTE_S3        = 4'h9;
  localparam logic [3:0] DATA_BITS_8    = 4'h8;
  localparam logic [3:0] DATA_BITS_9    = 4'h9;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_type;

endpackage

// >>> tb/async_rx_chk.sv
// port assertions for the asynchronous serial receiver
`timescale 1ns/10ps
`default_nettype none
module async_rx_chk
  import async_rx_pkg::*;
(
  input wire logic        clk_sys_in,
  input wire logic        rstn_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        baud_tick_in,
  input wire logic        receive_pin_in,
  input wire logic        receive_flag_out,
  input wire logic        rx_irq_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // saturating age of the last sampling tick
  logic [3:0] since_tick_reg;
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) since_tick_reg <= 4'hF;
    else if (baud_tick_in) since_tick_reg <= 4'h0;
    else if (since_tick_reg != 4'hF) since_tick_reg <= since_tick_reg + 4'h1;
  end
  ack_resp_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack missing one cycle after request");
  ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack without request");
  dat_idle_a: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
    else $error("read data not zero outside ack");
  dat_width_a: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
    else $error("upper read data bits set");
  irq_flag_a: assert property (rx_irq_out |-> receive_flag_out || $past(receive_flag_out))
    else $error("interrupt without receive flag");
  flag_tick_a: assert property ($rose(receive_flag_out) |-> since_tick_reg inside {[1:6]})
    else $error("receive flag rose away from stop tick");
  port_off_a: assert property (wb_ack_out && wb_we_in && wb_sel_in[0] && wb_adr_in == ADDR_RX_STATUS_CONTROL
      && !wb_dat_in[BIT_PORT_EN] |=> ##[0:2] !receive_flag_out && !rx_irq_out)
    else $error("port disable left flag set");
  cover property ($rose(receive_flag_out));
  cover property ($rose(rx_irq_out));
  cover property (wb_ack_out && !wb_we_in && wb_adr_in == ADDR_RX_DATA);
endmodule
bind async_serial_receiver async_rx_chk i_chk (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_dat_in(wb_dat_in), .wb_sel_in(wb_sel_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .baud_tick_in(baud_tick_in), .receive_pin_in(receive_pin_in), .receive_flag_out(receive_flag_out),
  .rx_irq_out(rx_irq_out));
`default_nettype wire

// >>> tb/serial_tx_model.sv
// remote serial transmitter model on the receive line
`timescale 1ns/10ps
`default_nettype none
module serial_tx_model (
  input  wire logic clk_in,
  input  wire logic tick_in,
  output var  logic line_out
);
  initial line_out = 1'b1;
  task automatic hold(input logic v, input int t);
    line_out <= v;
    repeat (t) @(posedge clk_in iff tick_in);
  endtask
  task automatic send(input logic [8:0] d, input int n, input logic stop);
    hold(1'b0, 16);
    for (int i = 0; i < n; i++) hold(d[i], 16);
    hold(stop, 16);
    // a low stop needs a mark bit before the next start edge
    if (!stop) hold(1'b1, 16);
  endtask
  // short low pulse: not a start bit
  task automatic glitch();
    hold(1'b0, 4);
    hold(1'b1, 16);
  endtask
endmodule
`default_nettype wire

// >>> tb/async_serial_receiver_tb.sv
// testbench for the asynchronous serial receiver
`timescale 1ns/10ps
`default_nettype none
module async_serial_receiver_tb;
  import async_rx_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        rstn_in    = 1'b0;
  logic        wb_cyc_in  = 1'b0;
  logic        wb_stb_in  = 1'b0;
  logic        wb_we_in   = 1'b0;
  logic [7:0]  wb_adr_in  = 8'h00;
  logic [31:0] wb_dat_in  = 32'h0;
  logic [3:0]  wb_sel_in  = 4'h0;
  logic        baud_tick_in = 1'b0;
  logic [3:0]  tick_cnt   = 4'h0;
  wire  logic  receive_pin_in;
  logic [31:0] wb_dat_out;
  logic        wb_ack_out;
  logic        receive_flag_out;
  logic        rx_irq_out;
  logic [31:0] exp_q[$];
  logic [7:0]  c[9];
  int          err_count   = 0;
  int          comparisons = 0;
  int          seed;
  localparam logic [7:0] CTL = ADDR_RX_STATUS_CONTROL;
  localparam logic [7:0] DAT = ADDR_RX_DATA;
  always #2.5 clk_sys_in = ~clk_sys_in;
  // sixteen-times tick every 16 clocks
  always @(posedge clk_sys_in) begin
    tick_cnt <= tick_cnt + 4'h1;
    baud_tick_in <= (tick_cnt == 4'hF);
  end
  async_serial_receiver i_dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_in(wb_dat_in),
    .wb_sel_in(wb_sel_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .baud_tick_in(baud_tick_in),
    .receive_pin_in(receive_pin_in), .receive_flag_out(receive_flag_out), .rx_irq_out(rx_irq_out));
  serial_tx_model i_tx (.clk_in(clk_sys_in), .tick_in(baud_tick_in), .line_out(receive_pin_in));
  task automatic end_sim();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  // monitor: each read ack takes the oldest expectation
  always @(posedge clk_sys_in) begin
    if (wb_ack_out === 1'b1 && wb_we_in === 1'b0 && exp_q.size() > 0) begin
      chk(wb_dat_out === exp_q.pop_front(), "read data");
    end
  end
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_adr_in <= a;
    wb_dat_in <= {24'h0, d};
    wb_sel_in <= 4'hF;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 20);
    if (wb_ack_out !== 1'b1) begin
      err_count++;
      end_sim();
    end
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    wb(1'b0, a, 8'h00);
  endtask
  task automatic settle();
    repeat (4) @(posedge clk_sys_in);
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys_in);
    err_count++;
    end_sim();
  end
  initial begin
    seed = 9514;
    foreach (c[i]) c[i] = 8'($random(seed));
    repeat (6) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    rd(CTL, RESET_RX_CTRL);
    rd(ADDR_TX_STATUS_CONTROL, RESET_TX_CTRL);
    rd(ADDR_BAUD_CONTROL, RESET_BAUD_CTRL | (8'h01 << BIT_RX_IDLE));
    rd(ADDR_INT_CONTROL, {5'h00, RESET_INT_CTRL});
    rd(8'h1C, 8'h00);
    wb(1'b1, ADDR_BAUD_DIV_LOW, c[8]);
    rd(ADDR_BAUD_DIV_LOW, c[8]);
    wb(1'b1, ADDR_BAUD_DIV_HIGH, c[7]);
    rd(ADDR_BAUD_DIV_HIGH, c[7]);
    wb(1'b1, ADDR_INT_CONTROL, 8'h07);
    rd(ADDR_INT_CONTROL, 8'h07);
    wb(1'b1, CTL, 8'h90);
    i_tx.glitch();
    i_tx.send({1'b0, c[0]}, 8, 1'b0);
    i_tx.send({1'b0, c[1]}, 8, 1'b1);
    settle();
    chk(receive_flag_out === 1'b1 && rx_irq_out === 1'b1, "flag or irq low");
    i_tx.send({1'b0, c[2]}, 8, 1'b1);
    i_tx.send({1'b0, c[3]}, 8, 1'b1);
    rd(CTL, 8'h96);
    wb(1'b1, CTL, 8'h80);
    rd(CTL, 8'h84);
    rd(DAT, c[0]);
    rd(CTL, 8'h80);
    rd(DAT, c[1]);
    settle();
    chk(receive_flag_out === 1'b0, "flag after draining");
    wb(1'b1, CTL, 8'hD8);
    i_tx.send({1'b0, c[4]}, 9, 1'b1);
    i_tx.send({1'b1, c[5]}, 9, 1'b1);
    rd(CTL, 8'hD9);
    rd(DAT, c[5]);
    settle();
    chk(receive_flag_out === 1'b0, "unaddressed character kept");
    wb(1'b1, CTL, 8'h90);
    i_tx.send({1'b0, c[6]}, 8, 1'b0);
    i_tx.send({1'b0, c[7]}, 8, 1'b0);
    wb(1'b1, ADDR_INT_CONTROL, 8'h03);
    wb(1'b1, DAT, 8'h00);
    settle();
    chk(receive_flag_out === 1'b1 && rx_irq_out === 1'b0, "irq without global enable");
    rd(CTL, 8'h94);
    rd(DAT, c[6]);
    rd(CTL, 8'h94);
    wb(1'b1, CTL, 8'h00);
    rd(CTL, 8'h00);
    settle();
    chk(receive_flag_out === 1'b0, "flag after port disable");
    wb(1'b1, ADDR_TX_STATUS_CONTROL, 8'h12);
    wb(1'b1, CTL, 8'h90);
    i_tx.send({1'b0, c[8]}, 8, 1'b1);
    settle();
    chk(receive_flag_out === 1'b0, "received in synchronous mode");
    end_sim();
  end
endmodule
`default_nettype wire
